//--- logic/tms_map.vh
`ifndef TMS_MAP_VH
`define TMS_MAP_VH
// Register offsets (byte addresses)
`define TMS_OFF_CTRL 12'h000
`define TMS_OFF_OPC 12'h004
`define TMS_OFF_DEST_LO 12'h008
`define TMS_OFF_DEST_HI 12'h00C
`define TMS_OFF_CNT_LO 12'h010
`define TMS_OFF_CNT_HI 12'h014
`define TMS_OFF_SRC_LO 12'h018
`define TMS_OFF_SRC_HI 12'h01C
`define TMS_OFF_STATUS 12'h020
`define TMS_OFF_NZCV 12'h024
// Control fields
`define TMS_CTRL_GO 0
`define TMS_CTRL_OPT_B 1
`define TMS_CTRL_FEAT_OPS 2
`define TMS_CTRL_FEAT_TAG 3
`define TMS_CTRL_NOP_ON_OVL 4
`define TMS_CTRL_RST 32'h0000000C
// Opcode register fields
`define TMS_OPC_RD_LSB 0
`define TMS_OPC_RN_LSB 5
`define TMS_OPC_SEL_LSB 12
`define TMS_OPC_RS_LSB 16
`define TMS_OPC_SZ_LSB 30
// Stage select encodings
`define TMS_SEL_PRO 4'h1
`define TMS_SEL_MAIN 4'h5
`define TMS_SEL_EPI 4'h9
`define TMS_REG_ZR 5'h1F
// Status bits
`define TMS_ST_BUSY 0
`define TMS_ST_DONE 1
`define TMS_ST_UNDEF 2
`define TMS_ST_NOP 3
`define TMS_ST_ALIGN 4
`define TMS_ST_TRANS 5
`define TMS_ST_EXT 6
// Granule
`define TMS_GRAN_BYTES 16
`define TMS_NZCV_A 4'h0
`define TMS_NZCV_B 4'h2
`endif

//--- logic/tms_chunk_size.v
`timescale 1ns/1ps
`default_nettype none
// Picks a chunk: whole granules, capped by stage remainder and a limit
module tms_chunk_size #(
    parameter [63:0] MAX_CHUNK = 64'h40
) (
    // Remaining bytes of the stage
    input wire [63:0] remain,
    // Chosen chunk in bytes
    output reg [63:0] chunk
);
    always @*
    begin
        if (remain >= MAX_CHUNK)
            chunk = MAX_CHUNK;
        else
            chunk = {remain[63:4], 4'h0};
    end
endmodule // tms_chunk_size
`default_nettype wire

//--- logic/tms_engine.v
// Contract
// - Fill destination with fill byte and write one tag per granule written; the code writes no tags for a chunk written short.
// - Tag value comes from logical tag bits of the first set address.
// - Fill byte is bits 7..0 of the source-data register.
// - Prologue preconditions and sets some; main sets some; epilogue finishes.
// - Option A prologue: dest+count, count negated plus bytes set, carry cleared.
// - Option B prologue: dest advances, count reduces by bytes set, carry set.
// - Only prologue writes flags: N,Z,V zero, carry per option.
// - Option A main: negative signed count, dest holds end, negated remainder back.
// - Option B main/epilogue: positive count, dest written as next unset address.
// - Epilogue writes zero to count at completion.
// - Stage select 0001 prologue, 0101 main, 1001 epilogue; upper 11 undefined.
// - Undefined if size field nonzero or either feature absent.
// - Overlapping register numbers or dest/count 31 give undefined or no-op.
// - Alignment fault on misaligned dest with nonzero count, or misaligned count.
// - Option A prologue moves dest to range end and negates count.
// - Chunk is a multiple of 16 not above stage remainder.
// - One tag stored at each 16-byte granule of a chunk.
// - Option B dest advances and counts drop; option A counts rise.
// - Short write stops, registers show progress, then abort is reported.
//
// The address map and the APB register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "tms_map.vh"
module tms_engine #(
    parameter [63:0] MAX_CHUNK = 64'h40,
    parameter [63:0] PRO_LIMIT = 64'h40,
    parameter [63:0] MAIN_LIMIT = 64'h100
) (
    // Clock, reset, enable
    input wire pclk,
    input wire presetn,
    input wire clk_en,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Memory data/tag write request
    output reg mem_req,
    output reg [63:0] mem_addr,
    output reg [63:0] mem_len,
    output reg [7:0] mem_fill,
    output reg [3:0] mem_tag,
    input wire mem_done,
    input wire [63:0] mem_written,
    input wire mem_trans_fault,
    // Tag write port
    output reg tag_we,
    output reg [63:0] tag_addr,
    output reg [3:0] tag_val,
    // Completion pulse and undefined indication
    output reg done_pulse,
    output reg undef_q
);
    localparam S_IDLE = 6'b000001;
    localparam S_DEC = 6'b000010;
    localparam S_REQ = 6'b000100;
    localparam S_WAIT = 6'b001000;
    localparam S_TAG = 6'b010000;
    localparam S_END = 6'b100000;

    reg [5:0] st_q;
    reg [31:0] ctrl_q;
    reg [31:0] opc_q;
    reg [63:0] dest_q;
    reg [63:0] cnt_q;
    reg [63:0] src_q;
    reg [3:0] nzcv_q;
    reg [6:0] stat_q;
    reg [63:0] stage_q;
    reg [63:0] chunk_q;
    reg [63:0] tstep_q;
    reg [63:0] base_q;
    reg optb_q;
    reg [1:0] stg_q;
    wire [63:0] stage_rem;
    wire [63:0] chunk_w;

    wire [4:0] rd = opc_q[`TMS_OPC_RD_LSB +: 5];
    wire [4:0] rn = opc_q[`TMS_OPC_RN_LSB +: 5];
    wire [4:0] rs = opc_q[`TMS_OPC_RS_LSB +: 5];
    wire [3:0] sel = opc_q[`TMS_OPC_SEL_LSB +: 4];
    wire [1:0] szf = opc_q[`TMS_OPC_SZ_LSB +: 2];

    function misaligned;
        input [63:0] a;
        input [63:0] n;
        begin
            misaligned = ((n != 64'h0) && (a[3:0] != 4'h0)) || (n[3:0] != 4'h0);
        end
    endfunction

    function [63:0] min64;
        input [63:0] a;
        input [63:0] b;
        begin
            min64 = (a < b) ? a : b;
        end
    endfunction

    // Stage remainder magnitude
    assign stage_rem = optb_q ? stage_q : (64'h0 - stage_q);

    tms_chunk_size #(
        .MAX_CHUNK(MAX_CHUNK)
    ) u_chunk (
        .remain(stage_rem),
        .chunk(chunk_w)
    );

    wire apb_wr = psel && penable && pwrite && pready && !pslverr;
    wire wr_ok = (paddr[1:0] == 2'b00) && (paddr <= `TMS_OFF_NZCV);
    wire apb_rd = psel && !penable && !pwrite;
    wire busy = !st_q[0];

    // Current chunk start address
    wire [63:0] cur_addr = optb_q ? dest_q : (dest_q + cnt_q);
    wire dec_b = (sel == `TMS_SEL_PRO) ? ctrl_q[`TMS_CTRL_OPT_B] : nzcv_q[1];
    wire [63:0] dec_addr = dec_b ? dest_q : (dest_q + cnt_q);
    wire [63:0] abs_cnt = dec_b ? cnt_q : (64'h0 - cnt_q);

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_q <= S_IDLE;
            ctrl_q <= `TMS_CTRL_RST;
            opc_q <= 32'h00000000;
            dest_q <= 64'h0;
            cnt_q <= 64'h0;
            src_q <= 64'h0;
            nzcv_q <= 4'h0;
            stat_q <= 7'h00;
            stage_q <= 64'h0;
            chunk_q <= 64'h0;
            tstep_q <= 64'h0;
            base_q <= 64'h0;
            optb_q <= 1'b0;
            stg_q <= 2'b00;
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            mem_req <= 1'b0;
            mem_addr <= 64'h0;
            mem_len <= 64'h0;
            mem_fill <= 8'h00;
            mem_tag <= 4'h0;
            tag_we <= 1'b0;
            tag_addr <= 64'h0;
            tag_val <= 4'h0;
            done_pulse <= 1'b0;
            undef_q <= 1'b0;
        end
        else if (clk_en)
        begin
            done_pulse <= 1'b0;
            tag_we <= 1'b0;
            // APB: one wait state, answer in access phase
            pready <= psel && penable && !pready;
            pslverr <= psel && penable && pwrite && !pready && (busy || !wr_ok);
            if (apb_rd)
            begin
                if (paddr == `TMS_OFF_CTRL)
                    prdata <= ctrl_q;
                else if (paddr == `TMS_OFF_OPC)
                    prdata <= opc_q;
                else if (paddr == `TMS_OFF_DEST_LO)
                    prdata <= dest_q[31:0];
                else if (paddr == `TMS_OFF_DEST_HI)
                    prdata <= dest_q[63:32];
                else if (paddr == `TMS_OFF_CNT_LO)
                    prdata <= cnt_q[31:0];
                else if (paddr == `TMS_OFF_CNT_HI)
                    prdata <= cnt_q[63:32];
                else if (paddr == `TMS_OFF_SRC_LO)
                    prdata <= src_q[31:0];
                else if (paddr == `TMS_OFF_SRC_HI)
                    prdata <= src_q[63:32];
                else if (paddr == `TMS_OFF_STATUS)
                    prdata <= {25'h0, stat_q[6:1], busy};
                else if (paddr == `TMS_OFF_NZCV)
                    prdata <= {28'h0, nzcv_q};
                else
                    prdata <= 32'h00000000;
            end
            if (apb_wr)
            begin
                if (paddr == `TMS_OFF_CTRL)
                    ctrl_q <= pwdata;
                else if (paddr == `TMS_OFF_OPC)
                    opc_q <= pwdata;
                else if (paddr == `TMS_OFF_DEST_LO)
                    dest_q[31:0] <= pwdata;
                else if (paddr == `TMS_OFF_DEST_HI)
                    dest_q[63:32] <= pwdata;
                else if (paddr == `TMS_OFF_CNT_LO)
                    cnt_q[31:0] <= pwdata;
                else if (paddr == `TMS_OFF_CNT_HI)
                    cnt_q[63:32] <= pwdata;
                else if (paddr == `TMS_OFF_SRC_LO)
                    src_q[31:0] <= pwdata;
                else if (paddr == `TMS_OFF_SRC_HI)
                    src_q[63:32] <= pwdata;
                else if (paddr == `TMS_OFF_NZCV)
                    nzcv_q <= pwdata[3:0];
                else if (paddr == `TMS_OFF_STATUS)
                    stat_q <= stat_q & ~pwdata[6:0];
            end
            case (st_q)
                S_IDLE:
                begin
                    if (ctrl_q[`TMS_CTRL_GO])
                    begin
                        ctrl_q[`TMS_CTRL_GO] <= 1'b0;
                        stat_q <= 7'h01;
                        undef_q <= 1'b0;
                        st_q <= S_DEC;
                    end
                end
                S_DEC:
                begin
                    if (szf != 2'b00 || !ctrl_q[`TMS_CTRL_FEAT_OPS] ||
                        !ctrl_q[`TMS_CTRL_FEAT_TAG] || sel[3:2] == 2'b11 ||
                        sel[1:0] != 2'b01)
                    begin
                        stat_q[`TMS_ST_UNDEF] <= 1'b1;
                        undef_q <= 1'b1;
                        st_q <= S_END;
                    end
                    else if (rs == rn || rs == rd || rn == rd ||
                             rd == `TMS_REG_ZR || rn == `TMS_REG_ZR)
                    begin
                        if (ctrl_q[`TMS_CTRL_NOP_ON_OVL])
                            stat_q[`TMS_ST_NOP] <= 1'b1;
                        else
                        begin
                            stat_q[`TMS_ST_UNDEF] <= 1'b1;
                            undef_q <= 1'b1;
                        end
                        st_q <= S_END;
                    end
                    else if (misaligned(dec_addr, abs_cnt) ||
                             (sel == `TMS_SEL_PRO && misaligned(dest_q, cnt_q)))
                    begin
                        stat_q[`TMS_ST_ALIGN] <= 1'b1;
                        st_q <= S_END;
                    end
                    else if (sel == `TMS_SEL_PRO)
                    begin
                        // Prologue preconditioning and flags
                        stg_q <= 2'b00;
                        optb_q <= ctrl_q[`TMS_CTRL_OPT_B];
                        base_q <= dest_q;
                        if (ctrl_q[`TMS_CTRL_OPT_B])
                        begin
                            nzcv_q <= `TMS_NZCV_B;
                            stage_q <= min64(cnt_q, PRO_LIMIT);
                        end
                        else
                        begin
                            nzcv_q <= `TMS_NZCV_A;
                            dest_q <= dest_q + cnt_q;
                            cnt_q <= 64'h0 - cnt_q;
                            stage_q <= 64'h0 - min64(cnt_q, PRO_LIMIT);
                        end
                        st_q <= S_REQ;
                    end
                    else
                    begin
                        // Option follows carry left by the prologue
                        optb_q <= nzcv_q[1];
                        stg_q <= (sel == `TMS_SEL_MAIN) ? 2'b01 : 2'b10;
                        base_q <= cur_addr;
                        if (sel == `TMS_SEL_MAIN)
                            stage_q <= nzcv_q[1] ? min64(cnt_q, MAIN_LIMIT) :
                                (64'h0 - min64(64'h0 - cnt_q, MAIN_LIMIT));
                        else
                            stage_q <= cnt_q;
                        st_q <= S_REQ;
                    end
                end
                S_REQ:
                begin
                    if (stage_rem[63:4] == 60'h0)
                        st_q <= S_END;
                    else
                    begin
                        // One request outstanding
                        chunk_q <= chunk_w;
                        mem_req <= 1'b1;
                        mem_addr <= cur_addr;
                        mem_len <= chunk_w;
                        mem_fill <= src_q[7:0];
                        mem_tag <= base_q[59:56];
                        st_q <= S_WAIT;
                    end
                end
                S_WAIT:
                begin
                    if (mem_done)
                    begin
                        mem_req <= 1'b0;
                        if (mem_written != chunk_q || mem_trans_fault)
                        begin
                            // Short write ends the stage
                            if (mem_trans_fault)
                                stat_q[`TMS_ST_TRANS] <= 1'b1;
                            else
                                stat_q[`TMS_ST_EXT] <= 1'b1;
                            st_q <= S_END;
                        end
                        else
                        begin
                            tstep_q <= {4'h0, chunk_q[63:4]};
                            st_q <= S_TAG;
                        end
                    end
                end
                S_TAG:
                begin
                    if (tstep_q == 64'h0)
                    begin
                        // Register progress
                        if (optb_q)
                        begin
                            dest_q <= dest_q + chunk_q;
                            cnt_q <= cnt_q - chunk_q;
                            stage_q <= stage_q - chunk_q;
                        end
                        else
                        begin
                            cnt_q <= cnt_q + chunk_q;
                            stage_q <= stage_q + chunk_q;
                        end
                        st_q <= S_REQ;
                    end
                    else
                    begin
                        tag_we <= 1'b1;
                        tag_addr <= mem_addr + {tstep_q[59:0] - 60'h1, 4'h0};
                        tag_val <= mem_tag;
                        tstep_q <= tstep_q - 64'h1;
                    end
                end
                S_END:
                begin
                    if (stg_q == 2'b10 && stat_q[6:2] == 5'h00)
                        cnt_q <= 64'h0;
                    stat_q[`TMS_ST_BUSY] <= 1'b0;
                    stat_q[`TMS_ST_DONE] <= 1'b1;
                    done_pulse <= 1'b1;
                    stg_q <= 2'b00;
                    st_q <= S_IDLE;
                end
                default:
                    st_q <= S_IDLE;
            endcase
        end
    end
endmodule // tms_engine
`default_nettype wire

//--- tb/tms_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module tms_mem_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Memory request and answer
    input wire logic mem_req,
    input wire logic [63:0] mem_len,
    output logic mem_done,
    output logic [63:0] mem_written,
    output logic mem_trans_fault,
    // Scenario control
    input wire logic [3:0] delay,
    input wire logic short_en,
    input wire logic trans_en
);
    logic [3:0] wait_q;
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wait_q <= 4'h0;
            mem_done <= 1'b0;
            mem_written <= 64'h0;
            mem_trans_fault <= 1'b0;
        end
        else if (mem_req && !mem_done && wait_q == delay)
        begin
            mem_done <= 1'b1;
            mem_written <= short_en ? mem_len - 64'h10 : mem_len;
            mem_trans_fault <= trans_en;
            wait_q <= 4'h0;
        end
        else
        begin
            // Written count and fault lines carry junk outside the completion cycle; done stays low
            mem_done <= 1'b0;
            mem_written <= ~mem_written;
            mem_trans_fault <= ~mem_trans_fault;
            wait_q <= (mem_req && !mem_done) ? wait_q + 4'h1 : 4'h0;
        end
    end
endmodule // tms_mem_model
`default_nettype wire

//--- tb/tms_engine_chk.sv
`timescale 1ns/1ps
`default_nettype none
module tms_engine_chk #(
    parameter MAX_CHUNK = 64
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Memory side
    input wire logic mem_req,
    input wire logic [63:0] mem_addr,
    input wire logic [63:0] mem_len,
    input wire logic mem_done,
    input wire logic [63:0] mem_written,
    // Tag side
    input wire logic tag_we,
    input wire logic [63:0] tag_addr
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [7:0] tcnt_q;
    logic [7:0] texp_q;
    // Tags counted per chunk against its granules, zero expected when the chunk was written short
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tcnt_q <= 8'h00;
            texp_q <= 8'h00;
        end
        else if (mem_req && mem_done)
        begin
            tcnt_q <= 8'h00;
            texp_q <= (mem_written == mem_len) ? mem_len[11:4] : 8'h00;
        end
        else if (tag_we)
            tcnt_q <= tcnt_q + 8'h01;
    end
    sequence s_full_done;
        mem_req && mem_done && mem_written == mem_len ##1 !mem_req;
    endsequence
    sequence s_tag_pair;
        tag_we ##1 tag_we;
    endsequence
    property p_req_hold;
        mem_req && !mem_done |=> mem_req && $stable(mem_addr) && $stable(mem_len);
    endproperty
    a_req_hold: assert property (p_req_hold) else $error("request dropped early");
    property p_req_drop;
        mem_req && mem_done |=> !mem_req;
    endproperty
    a_req_drop: assert property (p_req_drop) else $error("request held after done");
    property p_len;
        mem_req |-> mem_len[3:0] == 4'h0 && mem_len != 64'h0 && mem_len <= MAX_CHUNK;
    endproperty
    a_len: assert property (p_len) else $error("bad chunk length");
    property p_addr;
        mem_req |-> mem_addr[3:0] == 4'h0;
    endproperty
    a_addr: assert property (p_addr) else $error("chunk not on granule");
    property p_tag_quiet;
        mem_req |-> !tag_we;
    endproperty
    a_tag_quiet: assert property (p_tag_quiet) else $error("tag during request");
    property p_tag_al;
        tag_we |-> tag_addr[3:0] == 4'h0;
    endproperty
    a_tag_al: assert property (p_tag_al) else $error("tag off granule");
    property p_tag_desc;
        s_tag_pair |-> tag_addr == $past(tag_addr) - 64'h10;
    endproperty
    a_tag_desc: assert property (p_tag_desc) else $error("tag step wrong");
    property p_tag_cnt;
        $rose(mem_req) |-> tcnt_q == texp_q;
    endproperty
    a_tag_cnt: assert property (p_tag_cnt) else $error("tag count wrong");
    property p_tag_after;
        s_full_done |-> ##[0:4] tag_we;
    endproperty
    a_tag_after: assert property (p_tag_after) else $error("tags missing");
endmodule // tms_engine_chk
bind tms_engine tms_engine_chk #(.MAX_CHUNK(MAX_CHUNK)) i_tms_engine_chk (.pclk(pclk),
    .presetn(presetn), .mem_req(mem_req), .mem_addr(mem_addr), .mem_len(mem_len),
    .mem_done(mem_done), .mem_written(mem_written), .tag_we(tag_we), .tag_addr(tag_addr));
`default_nettype wire

//--- tb/tb_tagged_memory_set_engine.sv
`timescale 1ns/1ps
`default_nettype none
`include "tms_map.vh"
module tb_tagged_memory_set_engine;
    logic pclk = 1'b0, presetn = 1'b0, clk_en = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slv;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic pready, pslverr, mem_req, mem_done, mem_trans_fault, tag_we, done_pulse, undef_q;
    logic [63:0] mem_addr, mem_len, mem_written, tag_addr, tagb, d0, n0, v, c;
    logic [7:0] mem_fill;
    logic [3:0] mem_tag, tag_val, exp_tag, delay = 4'h0;
    logic short_en = 1'b0, trans_en = 1'b0;
    int fails = 0, checks = 0, nreq = 0, ndone = 0;
    logic [3:0] sel [3] = '{`TMS_SEL_PRO, `TMS_SEL_MAIN, `TMS_SEL_EPI};
    logic [31:0] f_opc [10] = '{32'h0003D041, 32'h40031041, 32'h00031041, 32'h00031041,
        32'h00031042, 32'h0003105F, 32'h00031041, 32'h00031041, 32'h00031041, 32'h00033041};
    logic [31:0] f_ctl [10] = '{32'hC, 32'hC, 32'h8, 32'h4, 32'hC, 32'h1C, 32'hC, 32'hC,
        32'hC, 32'hC};
    logic [31:0] f_d [10] = '{32'h1000, 32'h1000, 32'h1000, 32'h1000, 32'h1000, 32'h1000,
        32'h1008, 32'h1000, 32'h1008, 32'h1000};
    logic [31:0] f_n [10] = '{32'h40, 32'h40, 32'h40, 32'h40, 32'h40, 32'h40, 32'h40, 32'h18,
        32'h0, 32'h40};
    logic [31:0] f_st [10] = '{32'h4, 32'h4, 32'h4, 32'h4, 32'h4, 32'h8, 32'h10, 32'h10,
        32'h0, 32'h4};
    tms_engine i_tms_engine (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .mem_req(mem_req), .mem_addr(mem_addr),
        .mem_len(mem_len), .mem_fill(mem_fill), .mem_tag(mem_tag), .mem_done(mem_done),
        .mem_written(mem_written), .mem_trans_fault(mem_trans_fault), .tag_we(tag_we),
        .tag_addr(tag_addr), .tag_val(tag_val), .done_pulse(done_pulse), .undef_q(undef_q));
    tms_mem_model i_tms_mem_model (.pclk(pclk), .presetn(presetn), .mem_req(mem_req),
        .mem_len(mem_len), .mem_done(mem_done), .mem_written(mem_written),
        .mem_trans_fault(mem_trans_fault), .delay(delay), .short_en(short_en), .trans_en(trans_en));
    initial
        forever #5 pclk = ~pclk;
    task automatic results;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        checks++;
        if (g !== e)
        begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic hang;
        fails++;
        $display("mismatch wait expected answer seen timeout");
        results();
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk);
        while (pready !== 1'b1 && ++n < 20);
        rdat = prdata;
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        if (n >= 20) hang();
    endtask
    task automatic wr64(input logic [11:0] a, input logic [63:0] x);
        apb(1'b1, a, x[31:0]);
        apb(1'b1, a + 12'h4, x[63:32]);
    endtask
    task automatic rd64(input logic [11:0] a, output logic [63:0] x);
        apb(1'b0, a, 32'h0);
        x[31:0] = rdat;
        apb(1'b0, a + 12'h4, 32'h0);
        x[63:32] = rdat;
    endtask
    task automatic go(input logic [31:0] opc, input logic [31:0] ctl);
        int n;
        n = 0;
        apb(1'b1, `TMS_OFF_STATUS, 32'h7F);
        apb(1'b1, `TMS_OFF_OPC, opc);
        ndone = 0;
        apb(1'b1, `TMS_OFF_CTRL, ctl | 32'h1);
        do apb(1'b0, `TMS_OFF_STATUS, 32'h0);
        while ((rdat & 32'h7E) == 32'h0 && ++n < 200);
        if (n >= 200) hang();
        chk("done pulse", 1, ndone);
    endtask
    task automatic load(input logic [63:0] d, input logic [63:0] n);
        d0 = d;
        n0 = n;
        tagb = 64'h0;
        exp_tag = d[59:56];
        wr64(`TMS_OFF_DEST_LO, d);
        wr64(`TMS_OFF_CNT_LO, n);
    endtask
    task automatic seq3(input logic b, input logic [63:0] d, input logic [63:0] n);
        logic [3:0] fl;
        fl = {2'b11, b, 1'b0};
        load(d, n);
        for (int s = 0; s < 3; s++)
        begin
            go({16'h0003, sel[s], 12'h041}, 32'hC | {b, 1'b0});
            apb(1'b0, `TMS_OFF_NZCV, 32'h0);
            chk("nzcv", s == 0 ? {2'b00, b, 1'b0} : fl, rdat);
            if (s == 0) apb(1'b1, `TMS_OFF_NZCV, {28'h0, fl});
            rd64(`TMS_OFF_DEST_LO, v);
            rd64(`TMS_OFF_CNT_LO, c);
            chk("dest", b ? d0 + tagb : d0 + n0, v);
            chk("count", s == 2 ? 64'h0 : (b ? n0 - tagb : tagb - n0), c);
        end
        chk("bytes", n0, tagb);
    endtask
    always @(posedge pclk)
    begin
        if (tag_we)
        begin
            tagb += 64'h10;
            chk("tag value", exp_tag, tag_val);
            chk("tag addr", 1, tag_addr - d0 < n0);
        end
        if (done_pulse)
            ndone++;
        if (mem_req && mem_done)
        begin
            nreq++;
            chk("fill", 8'hC3, mem_fill);
        end
    end
    initial
    begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, `TMS_OFF_CTRL, 32'h0);
        chk("ctrl reset", `TMS_CTRL_RST, rdat);
        apb(1'b0, 12'h040, 32'h0);
        chk("unmapped read", 0, rdat);
        apb(1'b1, 12'h040, 32'h1);
        chk("unmapped write", 1, slv);
        apb(1'b1, `TMS_OFF_SRC_LO, 32'h123456C3);
        apb(1'b1, `TMS_OFF_SRC_HI, 32'h0);
        $display("test registers done");
        seq3(1'b1, 64'h0A00000000001000, 64'h100);
        $display("test option b done");
        delay <= 4'h3;
        seq3(1'b0, 64'h0500000000002000, 64'h80);
        $display("test option a done");
        for (int i = 0; i < 10; i++)
        begin
            nreq = 0;
            load({32'h0, f_d[i]}, {32'h0, f_n[i]});
            go(f_opc[i], f_ctl[i]);
            chk("status", f_st[i], rdat & 32'h7C);
            chk("undef", f_st[i] == 32'h4, undef_q);
            chk("requests", 0, nreq);
        end
        $display("test refusals done");
        short_en <= 1'b1;
        for (int i = 0; i < 2; i++)
        begin
            trans_en <= (i == 0);
            load(64'h3000, 64'h80);
            go(32'h00031041, 32'hE);
            chk("abort", i == 0 ? 32'h20 : 32'h40, rdat & 32'h60);
            rd64(`TMS_OFF_DEST_LO, v);
            chk("progress", d0 + tagb, v);
        end
        $display("test aborts done");
        results();
    end
endmodule // tb_tagged_memory_set_engine
`default_nettype wire
